// [design/qdh_host.sv]
// Host controller that loads the quad DAC over its serial port
`timescale 1ns/100ps
// What this block does
// - Frame sync goes low before any data bit is shifted.
// - Data is held steady across each falling serial clock edge.
// - Frame stays low across both bytes, sixteen bits in all.
// - Frame sync returns high after the second byte completes.
// - Bits go out most significant first; LSB-first words reversed.
// - Optional update pulse after each completed frame.
// - Or load several frames, then issue one update by software.
// - Internal clock, active low frame, sixteen bit word.
// - Data changes on rising serial clock edges; the first bit is set as frame sync falls.
// - Frame falls while clock is high, first bit meets next fall.
module qdh_host #(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             frame_sync_n_o,
	output logic             shift_clock_in_o,
	output logic             serial_data_in_o,
	output logic             update_outputs_n_o,
	output logic             clear_outputs_n_o
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	// ------------------------------------------------------------
	// Registers and signals
	// ------------------------------------------------------------
	qdh_pkg::qdh_state_e state_r;
	logic [3:0]          ctrl_r;
	logic [7:0]          div_r;
	logic [15:0]         shreg_r;
	logic [4:0]          bitcnt_r;
	logic [3:0]          strobe_r;
	logic                clr_r;
	logic [3:0]          clrcnt_r;
	logic                sd_r;
	logic                fs_r;
	logic                upd_r;
	logic [15:0]         wr_word;
	logic                wr_valid;
	logic                wr_ready;
	logic [15:0]         rd_word;
	logic                rd_valid;
	logic                rd_ready;
	logic [CW-1:0]       fifo_cnt;
	logic                run;
	logic                sclk;
	logic                rise;
	logic                fall;
	logic                acc;
	logic                upd_req;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	assign acc       = psel_i && penable_i;
	// Full FIFO stalls the write rather than dropping the word
	assign pready_o  = !(paddr_i == qdh_pkg::DATA_OFS && pwrite_i && !wr_ready);
	assign pslverr_o = 1'b0;
	assign wr_valid  = acc && pwrite_i && paddr_i == qdh_pkg::DATA_OFS;
	// Byte-wise reversal for software that packs LSB first
	assign wr_word   = ctrl_r[qdh_pkg::CTRL_LSB_SRC_BIT] ?
		{rev8(pwdata_i[15:8]), rev8(pwdata_i[7:0])} : pwdata_i[15:0];
	assign upd_req   = acc && pwrite_i && paddr_i == qdh_pkg::CTRL_OFS &&
		pwdata_i[qdh_pkg::CTRL_UPDATE_BIT];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_r <= qdh_pkg::CTRL_RST;
			div_r  <= qdh_pkg::DIV_RST;
		end else if (acc && pwrite_i) begin
			if (paddr_i == qdh_pkg::CTRL_OFS) begin
				ctrl_r <= {1'b0, pwdata_i[2:0]} | {pwdata_i[3], 3'b000};
				ctrl_r[qdh_pkg::CTRL_UPDATE_BIT] <= 1'b0;
			end
			if (paddr_i == qdh_pkg::DIV_OFS) begin
				div_r <= pwdata_i[7:0];
			end
		end
	end

	always_comb begin
		prdata_o = 32'h0000_0000;
		unique case (paddr_i)
			qdh_pkg::CTRL_OFS: prdata_o = {28'h0, ctrl_r};
			qdh_pkg::STATUS_OFS: begin
				prdata_o[qdh_pkg::STAT_BUSY_BIT]  = (state_r != qdh_pkg::QDH_IDLE);
				prdata_o[qdh_pkg::STAT_EMPTY_BIT] = !rd_valid;
				prdata_o[qdh_pkg::STAT_FULL_BIT]  = !wr_ready;
				prdata_o[qdh_pkg::STAT_CNT_LSB +: CW] = fifo_cnt;
			end
			qdh_pkg::DIV_OFS: prdata_o = {24'h0, div_r};
			default: prdata_o = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Word buffer and serial clock
	// ------------------------------------------------------------
	qdh_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.wr_data_i  (wr_word),
		.wr_valid_i (wr_valid),
		.wr_ready_o (wr_ready),
		.rd_data_o  (rd_word),
		.rd_valid_o (rd_valid),
		.rd_ready_i (rd_ready),
		.count_o    (fifo_cnt)
	);

	// Divider runs only while a frame is open; idle level is high
	assign run = (state_r == qdh_pkg::QDH_SHIFT);

	qdh_clkdiv u_div (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.run_i   (run),
		.half_i  (div_r),
		.sclk_o  (sclk),
		.rise_o  (rise),
		.fall_o  (fall)
	);

	// An update request owns the idle cycle, so no word is popped and lost
	assign rd_ready = (state_r == qdh_pkg::QDH_IDLE) && !clr_r && !upd_req;

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r  <= qdh_pkg::QDH_IDLE;
			shreg_r  <= 16'h0000;
			bitcnt_r <= 5'h00;
			strobe_r <= 4'h0;
			sd_r     <= 1'b0;
			fs_r     <= 1'b1;
			upd_r    <= 1'b1;
		end else begin
			unique case (state_r)
				qdh_pkg::QDH_IDLE: begin
					upd_r <= !upd_req;
					if (upd_req) begin
						strobe_r <= qdh_pkg::STROBE_CNT;
						state_r  <= qdh_pkg::QDH_UPDATE;
					end else if (rd_valid && rd_ready) begin
						// Code in 15:4, address 3:2, channel 1:0
						shreg_r  <= {rd_word[14:0], 1'b0};
						sd_r     <= rd_word[15];
						fs_r     <= 1'b0;
						bitcnt_r <= 5'h00;
						state_r  <= qdh_pkg::QDH_LEAD;
					end
				end
				qdh_pkg::QDH_LEAD: begin
					// Clock idles high when frame falls
					state_r <= qdh_pkg::QDH_SHIFT;
				end
				qdh_pkg::QDH_SHIFT: begin
					if (fall) begin
						bitcnt_r <= bitcnt_r + 5'h01;
						if (bitcnt_r == 5'(qdh_pkg::WORD_BITS - 1)) begin
							state_r <= qdh_pkg::QDH_TRAIL;
						end
					end else if (rise) begin
						sd_r    <= shreg_r[15];
						shreg_r <= {shreg_r[14:0], 1'b0};
					end
				end
				qdh_pkg::QDH_TRAIL: begin
					fs_r <= 1'b1;
					if (ctrl_r[qdh_pkg::CTRL_AUTO_UPD_BIT]) begin
						strobe_r <= qdh_pkg::STROBE_CNT;
						upd_r    <= 1'b0;
						state_r  <= qdh_pkg::QDH_UPDATE;
					end else begin
						state_r <= qdh_pkg::QDH_IDLE;
					end
				end
				qdh_pkg::QDH_UPDATE: begin
					upd_r <= 1'b0;
					if (strobe_r <= 4'h1) begin
						upd_r   <= 1'b1;
						state_r <= qdh_pkg::QDH_IDLE;
					end else begin
						strobe_r <= strobe_r - 4'h1;
					end
				end
				default: state_r <= qdh_pkg::QDH_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Clear strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			clr_r    <= 1'b0;
			clrcnt_r <= 4'h0;
		end else if (acc && pwrite_i && paddr_i == qdh_pkg::CTRL_OFS &&
				pwdata_i[qdh_pkg::CTRL_CLEAR_BIT]) begin
			clr_r    <= 1'b1;
			clrcnt_r <= qdh_pkg::STROBE_CNT;
		end else if (clr_r) begin
			if (clrcnt_r <= 4'h1) begin
				clr_r <= 1'b0;
			end else begin
				clrcnt_r <= clrcnt_r - 4'h1;
			end
		end
	end

	assign frame_sync_n_o     = fs_r;
	assign shift_clock_in_o   = sclk;
	assign serial_data_in_o   = sd_r;
	assign update_outputs_n_o = upd_r;
	assign clear_outputs_n_o  = !clr_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_frame_before_clock;
		@(posedge clk_i) disable iff (reset_i)
		$fell(shift_clock_in_o) |-> !frame_sync_n_o;
	endproperty
	a_frame_before_clock: assert property (p_frame_before_clock)
		else $error("clock fell outside frame");

	property p_data_stable_fall;
		@(posedge clk_i) disable iff (reset_i)
		fall |=> $stable(serial_data_in_o);
	endproperty
	a_data_stable_fall: assert property (p_data_stable_fall)
		else $error("data changed at falling edge");

	property p_frame_len;
		@(posedge clk_i) disable iff (reset_i)
		(fall && bitcnt_r == 5'h0f) |=> (state_r == qdh_pkg::QDH_TRAIL) ##1 frame_sync_n_o;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame not closed after sixteen bits");

	property p_frame_low_mid;
		@(posedge clk_i) disable iff (reset_i)
		(state_r == qdh_pkg::QDH_SHIFT) |-> !frame_sync_n_o;
	endproperty
	a_frame_low_mid: assert property (p_frame_low_mid)
		else $error("frame rose mid word");

	property p_msb_first;
		@(posedge clk_i) disable iff (reset_i)
		(state_r == qdh_pkg::QDH_IDLE && rd_valid && rd_ready && !upd_req)
		|=> serial_data_in_o == $past(rd_word[15]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("first bit not msb");

	property p_data_on_rise;
		@(posedge clk_i) disable iff (reset_i)
		(state_r == qdh_pkg::QDH_SHIFT && !$past(rise)) |-> $stable(serial_data_in_o);
	endproperty
	a_data_on_rise: assert property (p_data_on_rise)
		else $error("data changed off rising edge");

	property p_fs_clock_high;
		@(posedge clk_i) disable iff (reset_i)
		$fell(frame_sync_n_o) |-> shift_clock_in_o ##1 shift_clock_in_o;
	endproperty
	a_fs_clock_high: assert property (p_fs_clock_high)
		else $error("frame fell with clock low");

	property p_auto_update;
		@(posedge clk_i) disable iff (reset_i)
		(state_r == qdh_pkg::QDH_TRAIL && ctrl_r[qdh_pkg::CTRL_AUTO_UPD_BIT])
		|=> !update_outputs_n_o ##1 !update_outputs_n_o;
	endproperty
	a_auto_update: assert property (p_auto_update)
		else $error("update pulse missing after frame");

	property p_clear_pulse;
		@(posedge clk_i) disable iff (reset_i)
		$fell(clear_outputs_n_o) |-> !clear_outputs_n_o [*3];
	endproperty
	a_clear_pulse: assert property (p_clear_pulse)
		else $error("clear pulse too short");

	property p_sclk_idle_high;
		@(posedge clk_i) disable iff (reset_i)
		(state_r != qdh_pkg::QDH_SHIFT && state_r != qdh_pkg::QDH_TRAIL) |-> shift_clock_in_o;
	endproperty
	a_sclk_idle_high: assert property (p_sclk_idle_high)
		else $error("serial clock low outside frame");

	property p_frame_idle_high;
		@(posedge clk_i) disable iff (reset_i)
		(state_r == qdh_pkg::QDH_IDLE) |-> frame_sync_n_o;
	endproperty
	a_frame_idle_high: assert property (p_frame_idle_high)
		else $error("frame low while idle");

	property p_trail_count;
		@(posedge clk_i) disable iff (reset_i)
		(state_r == qdh_pkg::QDH_TRAIL) |-> (bitcnt_r == 5'h10);
	endproperty
	a_trail_count: assert property (p_trail_count)
		else $error("frame closed without sixteen bits");

	property p_sw_update;
		@(posedge clk_i) disable iff (reset_i)
		(state_r == qdh_pkg::QDH_IDLE && upd_req)
		|=> !update_outputs_n_o ##1 !update_outputs_n_o ##1 !update_outputs_n_o
		##1 update_outputs_n_o;
	endproperty
	a_sw_update: assert property (p_sw_update)
		else $error("software update pulse wrong");
endmodule

// [inc/qdh_pkg.sv]
// Package of constants for the quad DAC serial load host controller
package qdh_pkg;

	// ------------------------------------------------------------
	// Register map (APB byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] DATA_OFS   = 8'h08;
	localparam logic [7:0] DIV_OFS    = 8'h0c;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	localparam int CTRL_AUTO_UPD_BIT = 0;
	localparam int CTRL_CLEAR_BIT    = 1;
	localparam int CTRL_UPDATE_BIT   = 2;
	localparam int CTRL_LSB_SRC_BIT  = 3;

	// ------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_EMPTY_BIT = 1;
	localparam int STAT_FULL_BIT  = 2;
	localparam int STAT_CNT_LSB   = 8;

	// ------------------------------------------------------------
	// Word layout and reset values
	// ------------------------------------------------------------
	localparam int WORD_BITS    = 16;
	localparam int BYTE_BITS    = 8;
	localparam int CODE_MSB     = 15;
	localparam int CODE_LSB     = 4;
	localparam int ADDR_HI_BIT  = 3;
	localparam int ADDR_LO_BIT  = 2;
	localparam int CHAN_HI_BIT  = 1;
	localparam int CHAN_LO_BIT  = 0;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [7:0] DIV_RST  = 8'h03;

	// ------------------------------------------------------------
	// Strobe timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 25_000_000;
	localparam int STROBE_NS    = 100;
	localparam int STROBE_CYC   = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		QDH_IDLE   = 3'b000,
		QDH_LEAD   = 3'b001,
		QDH_SHIFT  = 3'b010,
		QDH_TRAIL  = 3'b011,
		QDH_UPDATE = 3'b100
	} qdh_state_e;

endpackage

// [design/qdh_fifo.sv]
// Word FIFO between the register bus and the serial shifter
`timescale 1ns/100ps
module qdh_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	input  wire logic [WIDTH-1:0]         wr_data_i,
	input  wire logic                     wr_valid_i,
	output logic                          wr_ready_o,
	output logic [WIDTH-1:0]              rd_data_o,
	output logic                          rd_valid_o,
	input  wire logic                     rd_ready_i,
	output logic [$clog2(DEPTH+1)-1:0]    count_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]          mem_r [DEPTH];
	logic [AW-1:0]             wp_r;
	logic [AW-1:0]             rp_r;
	logic [$clog2(DEPTH+1)-1:0] cnt_r;
	logic                      push;
	logic                      pop;

	assign wr_ready_o = (cnt_r != ($clog2(DEPTH+1))'(DEPTH));
	assign rd_valid_o = (cnt_r != '0);
	assign rd_data_o  = mem_r[rp_r];
	assign count_o    = cnt_r;
	assign push       = wr_valid_i && wr_ready_o;
	assign pop        = rd_valid_o && rd_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
		end
	end
endmodule

// [design/qdh_clkdiv.sv]
// Serial clock divider producing edge strobes and the link clock
`timescale 1ns/100ps
module qdh_clkdiv (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       run_i,
	input  wire logic [7:0] half_i,
	output logic            sclk_o,
	output logic            rise_o,
	output logic            fall_o
);
	logic [7:0] cnt_r;
	logic       sclk_r;
	logic       tick;

	// Idles high so frame sync can fall while the clock is high
	assign tick   = run_i && (cnt_r == half_i);
	assign sclk_o = sclk_r;
	assign rise_o = tick && !sclk_r;
	assign fall_o = tick && sclk_r;

	always_ff @(posedge clk_i) begin
		if (reset_i || !run_i) begin
			cnt_r  <= 8'h00;
			sclk_r <= 1'b1;
		end else if (tick) begin
			cnt_r  <= 8'h00;
			sclk_r <= !sclk_r;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule

// [test/qdh_dac_model.sv]
// Behavioural model of the quad DAC serial load port
`timescale 1ns/100ps
module qdh_dac_model #(
	parameter logic [1:0] DEV_ADDR = 2'b10
) (
	input  wire logic        frame_sync_n_i,
	input  wire logic        shift_clock_in_i,
	input  wire logic        serial_data_in_i,
	input  wire logic        update_outputs_n_i,
	input  wire logic        clear_outputs_n_i,
	output logic [47:0]      in_latch_o,
	output logic [47:0]      out_latch_o,
	output logic [7:0]       last_bits_o,
	output logic [7:0]       accepted_o,
	output logic [7:0]       viol_o
);
	logic [15:0] shift_r;
	logic [7:0]  bits_r;

	initial begin
		in_latch_o = '0;
		out_latch_o = '0;
		last_bits_o = '0;
		accepted_o = '0;
		viol_o = '0;
		shift_r = '0;
		bits_r = '0;
	end

	// ------------------------------------------------------------
	// Serial input
	// ------------------------------------------------------------
	// Frame fall must meet a high clock or the first bit is lost
	always @(negedge frame_sync_n_i) begin
		bits_r = 8'h00;
		if (shift_clock_in_i !== 1'b1)
			viol_o = viol_o + 8'h01;
	end
	always @(posedge frame_sync_n_i)
		last_bits_o = bits_r;
	always @(negedge shift_clock_in_i) begin
		if (frame_sync_n_i === 1'b0) begin
			shift_r = {shift_r[14:0], serial_data_in_i};
			bits_r = bits_r + 8'h01;
			if (bits_r == 8'h10 && shift_r[3:2] == DEV_ADDR) begin
				in_latch_o[32'(shift_r[1:0]) * 12 +: 12] = shift_r[15:4];
				accepted_o = accepted_o + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Output latches
	// ------------------------------------------------------------
	// Clear wins over update when both are low
	always @* begin
		if (clear_outputs_n_i === 1'b0)
			out_latch_o = '0;
		else if (update_outputs_n_i === 1'b0)
			out_latch_o = in_latch_o;
	end
endmodule

// [test/qdh_host_tb.sv]
// Self-checking bench for the quad DAC host controller
`timescale 1ns/100ps
module qdh_host_tb;
	logic        clk_i;
	logic        reset_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        fs_n;
	logic        sclk;
	logic        sdat;
	logic        upd_n;
	logic        clr_n;
	logic [47:0] in_l;
	logic [47:0] out_l;
	logic [7:0]  nbits;
	logic [7:0]  nacc;
	logic [7:0]  nviol;
	logic [31:0] rd_data;
	logic [47:0] exp_l;
	logic [15:0] w;
	int          miscompares = 0;
	int          total_checks = 0;
	int          i;

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	qdh_host #(.FIFO_DEPTH(32)) dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.frame_sync_n_o(fs_n), .shift_clock_in_o(sclk), .serial_data_in_o(sdat),
		.update_outputs_n_o(upd_n), .clear_outputs_n_o(clr_n));

	qdh_dac_model #(.DEV_ADDR(2'b10)) dac (.frame_sync_n_i(fs_n), .shift_clock_in_i(sclk),
		.serial_data_in_i(sdat), .update_outputs_n_i(upd_n), .clear_outputs_n_i(clr_n),
		.in_latch_o(in_l), .out_latch_o(out_l), .last_bits_o(nbits), .accepted_o(nacc),
		.viol_o(nviol));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task finish_test;
		if (miscompares == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [47:0] got, input logic [47:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Waits a free edge first so release and next setup never share a step
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 5000);
		rd_data = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (pready_o !== 1'b1) begin
			chk(48'h0, 48'h1, "apb timeout");
			finish_test;
		end
	endtask

	task send(input logic [15:0] wd);
		xfer(1'b1, qdh_pkg::DATA_OFS, {16'h0000, wd});
	endtask

	task wait_idle;
		int n;
		n = 0;
		do begin
			xfer(1'b0, qdh_pkg::STATUS_OFS, 32'h0);
			n++;
		end while ((rd_data[0] !== 1'b0 || rd_data[1] !== 1'b1) && n < 20000);
		if (rd_data[0] !== 1'b0 || rd_data[1] !== 1'b1) begin
			chk(48'h0, 48'h1, "idle timeout");
			finish_test;
		end
		repeat (6) @(posedge clk_i);
	endtask

	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int k = 0; k < 8; k++)
			rev8[k] = b[7-k];
	endfunction

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		reset_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		chk(48'({fs_n, sclk, upd_n, clr_n}), 48'hf, "idle pins");
		xfer(1'b0, qdh_pkg::CTRL_OFS, 32'h0);
		chk(48'(rd_data), 48'h0, "ctrl reset");
		xfer(1'b0, qdh_pkg::DIV_OFS, 32'h0);
		chk(48'(rd_data), 48'(qdh_pkg::DIV_RST), "div reset");
		xfer(1'b0, 8'h10, 32'h0);
		chk(48'({pslverr_o, rd_data}), 48'h0, "unmapped read");
		// Four channels, then one word for another device
		for (i = 0; i < 4; i++)
			send({12'ha50 + 12'(i), 2'b10, 2'(i)});
		send({12'hfff, 2'b01, 2'b00});
		wait_idle;
		exp_l = {12'ha53, 12'ha52, 12'ha51, 12'ha50};
		chk(in_l, exp_l, "input latches");
		chk(48'(nacc), 48'h4, "accepted");
		chk(48'(nbits), 48'h10, "frame bits");
		chk(out_l, 48'h0, "no update yet");
		xfer(1'b1, qdh_pkg::CTRL_OFS, 32'h4);
		repeat (6) @(posedge clk_i);
		chk(out_l, exp_l, "sw update");
		xfer(1'b0, qdh_pkg::CTRL_OFS, 32'h0);
		chk(48'(rd_data), 48'h0, "update self clears");
		xfer(1'b1, qdh_pkg::CTRL_OFS, 32'h2);
		repeat (6) @(posedge clk_i);
		chk(out_l, 48'h0, "clear");
		xfer(1'b1, qdh_pkg::CTRL_OFS, 32'h4);
		repeat (6) @(posedge clk_i);
		chk(out_l, exp_l, "restore");
		// Auto update after each frame
		xfer(1'b1, qdh_pkg::CTRL_OFS, 32'h1);
		send({12'h123, 2'b10, 2'b01});
		wait_idle;
		chk(48'(out_l[23:12]), 48'h123, "auto update");
		// Source word given least significant bit first
		xfer(1'b1, qdh_pkg::CTRL_OFS, 32'h9);
		xfer(1'b0, qdh_pkg::CTRL_OFS, 32'h0);
		chk(48'(rd_data), 48'h9, "ctrl readback");
		w = {12'h3c5, 2'b10, 2'b10};
		send({rev8(w[15:8]), rev8(w[7:0])});
		wait_idle;
		chk(48'(out_l[35:24]), 48'h3c5, "lsb source");
		// Slow link so the buffer fills and the bus stalls
		xfer(1'b1, qdh_pkg::CTRL_OFS, 32'h0);
		xfer(1'b1, qdh_pkg::DIV_OFS, 32'h1f);
		xfer(1'b0, qdh_pkg::DIV_OFS, 32'h0);
		chk(48'(rd_data), 48'h1f, "div readback");
		for (i = 0; i < 33; i++)
			send({12'(i), 2'b10, 2'b11});
		xfer(1'b0, qdh_pkg::STATUS_OFS, 32'h0);
		chk(48'({rd_data[13:8], rd_data[2]}), 48'h41, "fifo full");
		send({12'h0aa, 2'b10, 2'b11});
		wait_idle;
		chk(48'(in_l[47:36]), 48'h0aa, "last of burst");
		chk(48'(nacc), 48'h28, "burst accepted");
		chk(48'(nviol), 48'h0, "frame edge");
		finish_test;
	end
endmodule
